// [hw/ctb_defs.vh]
// Shared constants for the CAN transmit buffer block.
`ifndef CTB_DEFS_VH
`define CTB_DEFS_VH
`define CTB_NBUF          4
`define CTB_AW            6
`define CTB_RES_NONE      2'b00
`define CTB_RES_ABORT     2'b01
`define CTB_RES_DONE      2'b10
`define CTB_RES_DONE_AB   2'b11
`define CTB_PAGE_ONE      2'b01
// Per-buffer register groups: base = buffer * 8.
`define CTB_OFS_CTRL      3'h0
`define CTB_OFS_STAT      3'h1
`define CTB_OFS_IDL       3'h2
`define CTB_OFS_IDH       3'h3
`define CTB_OFS_FDC       3'h4
`define CTB_OFS_PTR       3'h5
// Global registers.
`define CTB_ADR_IRQEN     6'h20
`define CTB_ADR_REQSUM    6'h21
`define CTB_ADR_ABRSUM    6'h22
`define CTB_ADR_DONESUM   6'h23
`define CTB_ADR_ABCSUM    6'h24
`define CTB_ADR_HIST      6'h25
`define CTB_ADR_WIN       6'h26
`define CTB_ADR_LINK      6'h27
`define CTB_ADR_TXCTL     6'h28
// Control register bits.
`define CTB_CTRL_REQ      0
`define CTB_CTRL_ABR      1
// Status register bits.
`define CTB_STAT_PEND     3
// ID high bits.
`define CTB_IDH_RTR       14
`define CTB_IDH_HIST      15
// FD control bits.
`define CTB_FDC_FDF       2
`define CTB_FDC_BRS       1
`define CTB_FDC_ESI       0
// History control bits.
`define CTB_HIST_EN       0
`define CTB_HIST_DT       1
`endif

// [hw/ctb_prio.v]
// Priority selector: lowest identifier among pending buffers wins.
`timescale 1ns/1ps
`default_nettype none
module ctb_prio #(
  parameter NBUF = 4,
  parameter IDW  = 29
) (
  input  wire [NBUF-1:0]     pend,
  input  wire [NBUF*IDW-1:0] ids,
  output reg                 any,
  output reg  [1:0]          sel
);
  integer i;
  reg [IDW-1:0] best;

  // Strict less-than keeps the lower buffer number on equal ids.
  always @* begin
    any  = 1'b0;
    sel  = 2'h0;
    best = {IDW{1'b1}};
    for (i = 0; i < NBUF; i = i + 1) begin
      if (pend[i] && (!any || ids[i*IDW +: IDW] < best)) begin
        any  = 1'b1;
        sel  = i[1:0];
        best = ids[i*IDW +: IDW];
      end
    end
  end
endmodule // ctb_prio
`default_nettype wire

// [hw/ctb_top.v]
// CAN channel transmit buffers with priority selection and abort.
//
// Contract
// - Four transmit buffers, each standalone or FIFO-linked.
// - Linked buffers leave status and summaries untouched.
// - Writing request bit makes frame eligible.
// - Result reads 10, 11, 01 or 00.
// - Completion interrupt gated by buffer enable bit.
// - FD frames send RRS dominant always.
// - History stored only when all enables set.
// - Pick by priority and transmit it.
// - Arbitration loss keeps request, retries later.
// - Abort on pending buffer cancels its request.
// - Selected or in-flight aborts only on loss/error.
// - Abort completion: result 01, pending cleared.
// - Aborted in-flight success reports result 11.
//
// Strobed register access and the register offsets were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
`include "ctb_defs.vh"
module ctb_top #(
  parameter NBUF = `CTB_NBUF,
  parameter IDW  = 29
) (
  input  wire         CLK_SYS,
  input  wire         SRST,
  input  wire         CE,
  input  wire [5:0]   ADDR,
  input  wire [15:0]  WDATA,
  input  wire         WR,
  input  wire         RD,
  output reg  [15:0]  RDATA,
  input  wire         CH_ACTIVE,
  output reg          TX_START,
  output reg  [1:0]   TX_BUF,
  output reg  [28:0]  TX_ID,
  output reg          TX_RRS_RECESSIVE,
  output reg          TX_FDF,
  output reg          TX_BRS,
  output reg          TX_ESI,
  output reg  [15:0]  TX_LABEL,
  input  wire         TX_DONE,
  input  wire         TX_ARB_LOST,
  input  wire         TX_ERROR,
  output reg          HIST_STORE,
  output reg  [1:0]   HIST_BUF,
  output reg  [15:0]  HIST_LABEL,
  output reg  [NBUF-1:0] TX_CPL_EVENT
);
  // Per-buffer and global state held in flip-flops.
  reg [1:0]        result    [0:NBUF-1];
  reg [NBUF-1:0]   req;
  reg [NBUF-1:0]   abr;
  reg [NBUF-1:0]   pend;
  reg [15:0]       id_lo     [0:NBUF-1];
  reg [15:0]       id_hi     [0:NBUF-1];
  reg [2:0]        fdc       [0:NBUF-1];
  reg [15:0]       label     [0:NBUF-1];
  reg [NBUF-1:0]   irq_en;
  reg [NBUF-1:0]   linked;
  reg [1:0]        hist_ctl;
  reg [1:0]        win_page;
  reg              busy;
  reg [1:0]        cur;

  wire [2:0]        boff = ADDR[2:0];
  wire [1:0]        bidx = ADDR[4:3];
  wire              bsel = (ADDR[5] == 1'b0);
  wire              cwr  = CE && WR && bsel && !linked[bidx];
  wire              dwr  = cwr && !pend[bidx] && (win_page == `CTB_PAGE_ONE);
  wire [NBUF*IDW-1:0] ids;
  wire              any;
  wire [1:0]        nsel;
  wire              ended = busy && (TX_DONE || TX_ARB_LOST || TX_ERROR);

  // Identifier vector feeding the priority selector.
  genvar g;
  generate
    for (g = 0; g < NBUF; g = g + 1) begin : g_ids
      assign ids[g*IDW +: IDW] = {id_hi[g][12:0], id_lo[g]};
    end
  endgenerate

  // Only unlinked buffers with pending set compete; the one on the bus stays
  // pending, so a retry re-enters arbitration through the selector.
  ctb_prio #(.NBUF(NBUF), .IDW(IDW)) u_prio (
    .pend (pend & ~linked),
    .ids  (ids),
    .any  (any),
    .sel  (nsel)
  );

  // Per-buffer request, abort, result and pending state.
  integer i;
  always @(posedge CLK_SYS) begin
    if (SRST) begin
      req          <= {NBUF{1'b0}};
      abr          <= {NBUF{1'b0}};
      pend         <= {NBUF{1'b0}};
      TX_CPL_EVENT <= {NBUF{1'b0}};
      for (i = 0; i < NBUF; i = i + 1) begin
        result[i] <= `CTB_RES_NONE;
        id_lo[i]  <= 16'h0000;
        id_hi[i]  <= 16'h0000;
        fdc[i]    <= 3'h0;
        label[i]  <= 16'h0000;
      end
    end else if (CE) begin
      TX_CPL_EVENT <= {NBUF{1'b0}};
      for (i = 0; i < NBUF; i = i + 1) begin
        // Software clear of the result field; hardware updates below win.
        if (cwr && bidx == i && boff == `CTB_OFS_STAT &&
            WDATA[1:0] == `CTB_RES_NONE)
          result[i] <= `CTB_RES_NONE;
        if (dwr && bidx == i && boff == `CTB_OFS_IDL)
          id_lo[i] <= WDATA;
        if (dwr && bidx == i && boff == `CTB_OFS_IDH)
          id_hi[i] <= WDATA;
        if (dwr && bidx == i && boff == `CTB_OFS_FDC)
          fdc[i] <= WDATA[2:0];
        if (dwr && bidx == i && boff == `CTB_OFS_PTR)
          label[i] <= WDATA;
        // Control write: request and abort bits.
        if (cwr && bidx == i && boff == `CTB_OFS_CTRL && CH_ACTIVE) begin
          req[i] <= WDATA[`CTB_CTRL_REQ];
          abr[i] <= WDATA[`CTB_CTRL_ABR] && WDATA[`CTB_CTRL_REQ];
          if (WDATA[`CTB_CTRL_REQ] && !pend[i])
            pend[i] <= 1'b1;
          // A pending buffer neither on the bus nor selected cancels at once.
          if (WDATA[`CTB_CTRL_ABR] && pend[i] &&
              !(busy && cur == i) && !(any && nsel == i)) begin
            pend[i]   <= 1'b0;
            req[i]    <= 1'b0;
            // A finished abort must not linger in the abort summary.
            abr[i]    <= 1'b0;
            result[i] <= `CTB_RES_ABORT;
          end
        end
        // End of the frame on the bus for the buffer in flight.
        if (ended && cur == i) begin
          if (TX_DONE) begin
            pend[i]   <= 1'b0;
            req[i]    <= 1'b0;
            abr[i]    <= 1'b0;
            result[i] <= abr[i] ? `CTB_RES_DONE_AB
                                : `CTB_RES_DONE;
            TX_CPL_EVENT[i] <= irq_en[i];
          end else if (abr[i]) begin
            pend[i]   <= 1'b0;
            req[i]    <= 1'b0;
            abr[i]    <= 1'b0;
            result[i] <= `CTB_RES_ABORT;
          end
          // Loss or error without abort leaves pending set to retry.
        end
      end
    end
  end

  // Transmit sequencer: launch winner, wait for the bus outcome.
  always @(posedge CLK_SYS) begin
    if (SRST) begin
      busy             <= 1'b0;
      cur              <= 2'h0;
      TX_START         <= 1'b0;
      TX_BUF           <= 2'h0;
      TX_ID            <= 29'h0;
      TX_RRS_RECESSIVE <= 1'b0;
      TX_FDF           <= 1'b0;
      TX_BRS           <= 1'b0;
      TX_ESI           <= 1'b0;
      TX_LABEL         <= 16'h0000;
      HIST_STORE       <= 1'b0;
      HIST_BUF         <= 2'h0;
      HIST_LABEL       <= 16'h0000;
    end else if (CE) begin
      TX_START   <= 1'b0;
      HIST_STORE <= 1'b0;
      if (ended) begin
        busy <= 1'b0;
        // History capture happens only on a frame that really completed.
        if (TX_DONE && hist_ctl[`CTB_HIST_EN] && hist_ctl[`CTB_HIST_DT] &&
            id_hi[cur][`CTB_IDH_HIST]) begin
          HIST_STORE <= 1'b1;
          HIST_BUF   <= cur;
          HIST_LABEL <= label[cur];
        end
      end else if (!busy && any && CH_ACTIVE &&
                   !(WR && bsel && bidx == nsel)) begin
        busy     <= 1'b1;
        cur      <= nsel;
        TX_START <= 1'b1;
        TX_BUF   <= nsel;
        TX_ID    <= ids[nsel*IDW +: IDW];
        TX_FDF   <= fdc[nsel][`CTB_FDC_FDF];
        TX_BRS   <= fdc[nsel][`CTB_FDC_BRS];
        TX_ESI   <= fdc[nsel][`CTB_FDC_ESI];
        TX_LABEL <= label[nsel];
        // FD frames carry a dominant RRS whatever the remote bit says.
        TX_RRS_RECESSIVE <= !fdc[nsel][`CTB_FDC_FDF] &&
                            id_hi[nsel][`CTB_IDH_RTR];
      end
    end
  end

  // Global configuration registers.
  always @(posedge CLK_SYS) begin
    if (SRST) begin
      irq_en   <= {NBUF{1'b0}};
      linked   <= {NBUF{1'b0}};
      hist_ctl <= 2'h0;
      win_page <= 2'h0;
    end else if (CE && WR) begin
      case (ADDR)
        `CTB_ADR_IRQEN: irq_en   <= WDATA[NBUF-1:0];
        `CTB_ADR_HIST:  hist_ctl <= WDATA[1:0];
        `CTB_ADR_WIN:   win_page <= WDATA[1:0];
        `CTB_ADR_LINK:  linked   <= WDATA[NBUF-1:0];
        default: ;
      endcase
    end
  end

  // Summary vectors mask linked buffers so their bits stay at zero.
  reg [NBUF-1:0] done_v;
  reg [NBUF-1:0] abc_v;
  always @* begin
    for (i = 0; i < NBUF; i = i + 1) begin
      done_v[i] = !linked[i] && result[i][1];
      abc_v[i]  = !linked[i] && (result[i] == `CTB_RES_ABORT);
    end
  end

  // Read data one cycle after the strobe, zero otherwise.
  always @(posedge CLK_SYS) begin
    if (SRST) begin
      RDATA <= 16'h0000;
    end else if (CE) begin
      RDATA <= 16'h0000;
      if (RD) begin
        if (bsel) begin
          case (boff)
            `CTB_OFS_CTRL: RDATA <= {14'h0, abr[bidx], req[bidx]};
            `CTB_OFS_STAT: RDATA <= linked[bidx] ? 16'h0000 :
                                   {12'h0, pend[bidx], 1'b0,
                                    result[bidx]};
            `CTB_OFS_IDL:  RDATA <= id_lo[bidx];
            `CTB_OFS_IDH:  RDATA <= id_hi[bidx];
            `CTB_OFS_FDC:  RDATA <= {13'h0, fdc[bidx]};
            `CTB_OFS_PTR:  RDATA <= label[bidx];
            default:       RDATA <= 16'h0000;
          endcase
        end else begin
          case (ADDR)
            `CTB_ADR_IRQEN:   RDATA <= {12'h0, irq_en};
            `CTB_ADR_REQSUM:  RDATA <= {12'h0, pend & ~linked};
            `CTB_ADR_ABRSUM:  RDATA <= {12'h0, abr & ~linked};
            `CTB_ADR_DONESUM: RDATA <= {12'h0, done_v};
            `CTB_ADR_ABCSUM:  RDATA <= {12'h0, abc_v};
            `CTB_ADR_HIST:    RDATA <= {14'h0, hist_ctl};
            `CTB_ADR_WIN:     RDATA <= {14'h0, win_page};
            `CTB_ADR_LINK:    RDATA <= {12'h0, linked};
            `CTB_ADR_TXCTL:   RDATA <= {13'h0, busy, cur};
            default:          RDATA <= 16'h0000;
          endcase
        end
      end
    end
  end
endmodule // ctb_top
`default_nettype wire

// [tb/ctb_bus_model.sv]
// Behavioural bus engine that ends each launched frame after a delay.
`timescale 1ns/1ps
`default_nettype none
module ctb_bus_model (
  input  wire logic       clk,
  input  wire logic       start,
  input  wire logic [3:0] dly,
  input  wire logic [1:0] losses,
  input  wire logic       fail_err,
  output var  logic       done,
  output var  logic       lost,
  output var  logic       err
);
  int cnt = 0;
  int nl = 0;

  initial {done, lost, err} = 3'b000;

  // Losses are counted up to the next success, so one loss setting can
  // span several frames; each frame ends with exactly one pulse.
  always @(posedge clk) begin
    {done, lost, err} <= 3'b000;
    if (start) cnt <= dly + 1;
    else if (cnt > 1) cnt <= cnt - 1;
    else if (cnt == 1) begin
      cnt <= 0;
      if (nl < losses) begin
        nl <= nl + 1;
        if (fail_err) err <= 1'b1; else lost <= 1'b1;
      end else begin
        nl <= 0;
        done <= 1'b1;
      end
    end
  end
endmodule // ctb_bus_model
`default_nettype wire

// [tb/ctb_top_monitor.sv]
// Concurrent port checks for the CAN transmit buffer block.
`timescale 1ns/1ps
`default_nettype none
module ctb_top_monitor #(
  parameter NBUF = 4
) (
  input wire logic            CLK_SYS,
  input wire logic            SRST,
  input wire logic            RD,
  input wire logic [15:0]     RDATA,
  input wire logic            CH_ACTIVE,
  input wire logic            TX_START,
  input wire logic [1:0]      TX_BUF,
  input wire logic [28:0]     TX_ID,
  input wire logic            TX_FDF,
  input wire logic            TX_RRS_RECESSIVE,
  input wire logic            TX_DONE,
  input wire logic            TX_ARB_LOST,
  input wire logic            TX_ERROR,
  input wire logic [NBUF-1:0] TX_CPL_EVENT
);
  logic busy;

  default clocking @(posedge CLK_SYS); endclocking
  default disable iff (SRST);

  // A frame is in flight from its launch until the engine ends it.
  always @(posedge CLK_SYS) begin
    if (SRST) busy <= 1'b0;
    else if (TX_START) busy <= 1'b1;
    else if (TX_DONE || TX_ARB_LOST || TX_ERROR) busy <= 1'b0;
  end

  AST_RRS_FD: assert property (
      TX_START && TX_FDF |-> !TX_RRS_RECESSIVE)
    else $error("fd frame launched with recessive rrs");
  AST_RD_IDLE: assert property (
      !$past(RD) |-> RDATA == 16'h0000)
    else $error("read data present without a read");
  AST_ONE_FRAME: assert property (TX_START |-> !busy)
    else $error("launch while a frame is still in flight");
  AST_START_GAP: assert property (TX_START |=> !TX_START)
    else $error("launch pulse longer than one cycle");
  AST_START_ACT: assert property (
      TX_START |-> $past(CH_ACTIVE))
    else $error("launch while channel inactive");
  AST_HOLD: assert property (
      !TX_START |-> $stable(TX_ID) && $stable(TX_BUF))
    else $error("frame fields changed between launches");
  AST_CPL_CAUSE: assert property (
      |TX_CPL_EVENT |-> $past(TX_DONE) || $past(TX_DONE, 2))
    else $error("completion event without a finished frame");
  AST_CPL_BUF: assert property (
      |TX_CPL_EVENT && !TX_START |-> TX_CPL_EVENT == NBUF'(1) << TX_BUF)
    else $error("completion event on the wrong buffer");
endmodule // ctb_top_monitor

bind ctb_top ctb_top_monitor #(.NBUF(NBUF)) ctb_top_monitor_inst (
  .CLK_SYS(CLK_SYS), .SRST(SRST), .RD(RD), .RDATA(RDATA),
  .CH_ACTIVE(CH_ACTIVE), .TX_START(TX_START), .TX_BUF(TX_BUF),
  .TX_ID(TX_ID), .TX_FDF(TX_FDF), .TX_RRS_RECESSIVE(TX_RRS_RECESSIVE),
  .TX_DONE(TX_DONE), .TX_ARB_LOST(TX_ARB_LOST), .TX_ERROR(TX_ERROR),
  .TX_CPL_EVENT(TX_CPL_EVENT));
`default_nettype wire

// [tb/tb_top.sv]
// Self-checking bench for the CAN transmit buffer block.
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) begin checks++; if ((a) !== (e)) begin failures++; \
  $display("unexpected at %0t got %h want %h", $time, a, e); end end
module tb_top;
  logic        CLK_SYS = 0;
  logic        SRST = 1;
  logic [5:0]  ADDR = 0;
  logic [15:0] WDATA = 0;
  logic        WR = 0;
  logic        RD = 0;
  logic        CH_ACTIVE = 1;
  logic [3:0]  dly = 4'hf;
  logic [1:0]  losses = 0;
  logic        fail_err = 0;
  wire  [15:0] RDATA;
  wire  [1:0]  TX_BUF;
  wire  [3:0]  TX_CPL_EVENT;
  wire         TX_START, TX_DONE, TX_ARB_LOST, TX_ERROR, HIST_STORE;
  wire  [28:0] TX_ID;
  wire         TX_RRS_RECESSIVE;
  logic [28:0] id1 = 0;
  logic        rrs1 = 1;
  int          failures = 0;
  int          checks = 0;
  int          hists = 0;
  logic [3:0]  cpl = 0;
  logic [1:0]  starts[$];
  logic [1:0]  order[12] = '{3, 1, 2, 0, 1, 1, 1, 3, 1, 3, 3, 3};

  ctb_top ctb_top_inst (.CLK_SYS(CLK_SYS), .SRST(SRST), .CE(1'b1),
    .ADDR(ADDR), .WDATA(WDATA), .WR(WR), .RD(RD), .RDATA(RDATA),
    .CH_ACTIVE(CH_ACTIVE), .TX_START(TX_START), .TX_BUF(TX_BUF),
    .TX_ID(TX_ID), .TX_RRS_RECESSIVE(TX_RRS_RECESSIVE), .TX_FDF(),
    .TX_BRS(), .TX_ESI(),
    .TX_LABEL(), .TX_DONE(TX_DONE), .TX_ARB_LOST(TX_ARB_LOST),
    .TX_ERROR(TX_ERROR), .HIST_STORE(HIST_STORE), .HIST_BUF(),
    .HIST_LABEL(), .TX_CPL_EVENT(TX_CPL_EVENT));
  ctb_bus_model ctb_bus_model_inst (.clk(CLK_SYS), .start(TX_START),
    .dly(dly), .losses(losses), .fail_err(fail_err), .done(TX_DONE),
    .lost(TX_ARB_LOST), .err(TX_ERROR));

  always #5 CLK_SYS = ~CLK_SYS;

  // Launch order, history pulses and completion events are logged here.
  always @(posedge CLK_SYS) begin
    if (TX_START === 1'b1) starts.push_back(TX_BUF);
    if (TX_START === 1'b1 && TX_BUF === 2'd1) begin
      id1 <= TX_ID;
      rrs1 <= TX_RRS_RECESSIVE;
    end
    if (HIST_STORE === 1'b1) hists++;
    if (!SRST) cpl <= cpl | TX_CPL_EVENT;
  end

  task wr(input logic [5:0] a, input logic [15:0] d);
    ADDR <= a;
    WDATA <= d;
    WR <= 1'b1;
    @(posedge CLK_SYS);
    WR <= 1'b0;
    @(posedge CLK_SYS);
  endtask

  // Read data is checked mid-cycle, where the one-cycle answer stands.
  task rd(input logic [5:0] a, input logic [15:0] e);
    ADDR <= a;
    RD <= 1'b1;
    @(posedge CLK_SYS);
    RD <= 1'b0;
    @(negedge CLK_SYS);
    `CHK(RDATA, e)
    @(posedge CLK_SYS);
  endtask

  task clr();
    for (int m = 0; m < 4; m++) wr(6'(8 * m + 1), 16'h0000);
    repeat (40) @(posedge CLK_SYS);
  endtask

  task tally_and_finish();
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  initial begin
    repeat (4000) @(posedge CLK_SYS);
    failures++;
    tally_and_finish();
  end

  initial begin
    repeat (12) @(posedge CLK_SYS);
    SRST <= 1'b0;
    @(posedge CLK_SYS);
    wr(6'h26, 16'h0001);
    wr(6'h25, 16'h0003);
    wr(6'h20, 16'h000e);
    // Refused writes: control while inactive, data outside page one.
    CH_ACTIVE <= 1'b0;
    wr(6'h00, 16'h0001);
    CH_ACTIVE <= 1'b1;
    rd(6'h01, 16'h0000);
    wr(6'h26, 16'h0000);
    wr(6'h02, 16'h0055);
    wr(6'h26, 16'h0001);
    rd(6'h02, 16'h0000);
    // Buffer 1 is an FD frame with the remote bit set; buffer 2 stores.
    wr(6'h02, 16'h0300);
    wr(6'h0a, 16'h0100);
    wr(6'h0b, 16'h4000);
    wr(6'h0c, 16'h0004);
    wr(6'h12, 16'h0100);
    wr(6'h13, 16'h8000);
    wr(6'h1a, 16'h07ff);
    wr(6'h1c, 16'h0000);
    wr(6'h18, 16'h0001);
    wr(6'h00, 16'h0001);
    wr(6'h08, 16'h0001);
    wr(6'h10, 16'h0001);
    rd(6'h09, 16'h0008);
    repeat (100) @(posedge CLK_SYS);
    for (int m = 0; m < 4; m++) rd(6'(8 * m + 1), 16'h0002);
    `CHK(cpl, 4'he)
    `CHK(hists, 1)
    `CHK(id1, 29'h0000100)
    `CHK(rrs1, 1'b0)
    clr();
    $display("priority test done");
    losses <= 2'd2;
    wr(6'h08, 16'h0001);
    repeat (80) @(posedge CLK_SYS);
    rd(6'h09, 16'h0002);
    losses <= 2'd0;
    clr();
    $display("retry test done");
    wr(6'h18, 16'h0001);
    wr(6'h08, 16'h0001);
    wr(6'h00, 16'h0001);
    wr(6'h00, 16'h0003);
    rd(6'h01, 16'h0001);
    rd(6'h22, 16'h0000);
    repeat (60) @(posedge CLK_SYS);
    rd(6'h09, 16'h0002);
    clr();
    wr(6'h18, 16'h0001);
    wr(6'h18, 16'h0003);
    repeat (40) @(posedge CLK_SYS);
    rd(6'h19, 16'h0003);
    clr();
    // The first pass loses arbitration, the second hits a bus error.
    for (int e = 0; e < 2; e++) begin
      losses <= 2'(e + 1);
      fail_err <= 1'(e);
      wr(6'h18, 16'h0001);
      wr(6'h18, 16'h0003);
      repeat (40) @(posedge CLK_SYS);
      rd(6'h19, 16'h0001);
      clr();
    end
    $display("abort test done");
    // Buffer 0 joins the FIFO: its control is zeroed first, then requests
    // to it are ignored and its status and summary bits stay clear.
    wr(6'h00, 16'h0000);
    wr(6'h27, 16'h0001);
    wr(6'h00, 16'h0001);
    rd(6'h01, 16'h0000);
    rd(6'h21, 16'h0000);
    wr(6'h27, 16'h0000);
    $display("link test done");
    `CHK(starts.size(), 12)
    for (int i = 0; i < 12; i++) `CHK(starts[i], order[i])
    tally_and_finish();
  end
endmodule // tb_top
`default_nettype wire
